//--- hdl/endpoint_fifo_control_defines.vh
`ifndef ENDPOINT_FIFO_CONTROL_DEFINES_VH
`define ENDPOINT_FIFO_CONTROL_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OFS_SELECT        8'h00
`define OFS_CONTROL       8'h04
`define OFS_BYTE_COUNT    8'h08
`define OFS_LINK_CONTROL  8'h0C
`define OFS_IRQ_STATUS    8'h10
`define OFS_IRQ_MASK      8'h14

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define SEL_DIR_BIT       0
`define DIR_IN            1'h1
`define CTL_ENABLE_BIT    3
`define CTL_STALL_BIT     2
`define CTL_TOGGLE_BIT    1
`define CTL_BUSY_BIT      0
`define LNK_ENABLE_BIT    0
`define CNT_W             7
`define EVT_IN_DONE       0
`define EVT_OUT_DONE      1
`define EVT_STALL         2
`define EVT_W             3

////////////////////////////////////////////////////////////////////////////////
// Reset values and bit levels
`define RST_ENABLE        1'h1
`define RST_LINK          1'h0
`define RST_SELECT        5'h00
`define RST_MASK          3'h0
`define BIT_CLR           1'h0
`define BIT_SET           1'h1

////////////////////////////////////////////////////////////////////////////////
// Reply codes to the serial engine
`define RPL_NONE          2'h0
`define RPL_DATA          2'h1
`define RPL_NAK           2'h2
`define RPL_STALL         2'h3

`endif

//--- hdl/endpoint_slot_state.v
`timescale 1ns/1ns
`default_nettype none
`include "endpoint_fifo_control_defines.vh"

module endpoint_slot_state
(
  input  wire pclk,
  input  wire presetn,
  input  wire cpu_write,
  input  wire cpu_enable,
  input  wire cpu_stall,
  input  wire cpu_toggle,
  input  wire toggle_clear,
  input  wire toggle_flip,
  input  wire busy_set,
  input  wire busy_clear,
  output wire enable,
  output wire stall,
  output wire toggle,
  output wire busy
);

  reg enable_reg;
  reg stall_reg;
  reg toggle_reg;
  reg busy_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Per slot state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_reg <= `RST_ENABLE; // RULE1
      stall_reg  <= `BIT_CLR;
      toggle_reg <= `BIT_CLR;
      busy_reg   <= `BIT_CLR;
    end
    else
    begin
      if (cpu_write)
      begin
        enable_reg <= cpu_enable;
        stall_reg  <= cpu_stall; // RULE2
      end
      if (toggle_clear)
        toggle_reg <= `BIT_CLR; // RULE9
      else if (cpu_write && !enable_reg && cpu_enable)
        toggle_reg <= `BIT_CLR; // RULE10
      else if (cpu_write)
        toggle_reg <= cpu_toggle; // RULE8
      else if (toggle_flip)
        toggle_reg <= ~toggle_reg; // RULE4 RULE6
      if (busy_set)
        busy_reg <= `BIT_SET; // RULE11 RULE13
      else if (busy_clear)
        busy_reg <= `BIT_CLR; // RULE14
    end
  end

  assign enable = enable_reg;
  assign stall  = stall_reg;
  assign toggle = toggle_reg;
  assign busy   = busy_reg;

endmodule
`default_nettype wire

//--- hdl/event_irq_bank.v
`timescale 1ns/1ns
`default_nettype none
`include "endpoint_fifo_control_defines.vh"

module event_irq_bank
(
  input  wire              pclk,
  input  wire              presetn,
  input  wire [`EVT_W-1:0] events,
  input  wire              status_write,
  input  wire              mask_write,
  input  wire [`EVT_W-1:0] wdata,
  output wire [`EVT_W-1:0] status,
  output wire [`EVT_W-1:0] mask,
  output wire              irq
);

  reg [`EVT_W-1:0] status_reg;
  reg [`EVT_W-1:0] mask_reg;
  reg [`EVT_W-1:0] status_next;

  //////////////////////////////////////////////////////////////////////////////
  // Write one to clear, set wins
  always @*
  begin
    status_next = status_reg;
    if (status_write)
      status_next = status_next & ~wdata;
    status_next = status_next | events;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_reg <= `RST_MASK;
      mask_reg   <= `RST_MASK;
    end
    else
    begin
      status_reg <= status_next;
      if (mask_write)
        mask_reg <= wdata;
    end
  end

  assign status = status_reg;
  assign mask   = mask_reg;
  assign irq    = |(status_reg & mask_reg);

endmodule
`default_nettype wire

//--- hdl/endpoint_fifo_control.v
// Notes on behaviour
// RULE1 - All endpoint FIFOs enabled after reset
// RULE2 - Stall bit answers every token with STALL
// RULE3 - IN data PID follows toggle bit
// RULE4 - IN toggle flips only on host ACK
// RULE5 - OUT toggle gives expected data PID
// RULE6 - OUT toggle flips on good packet only
// RULE7 - Wrong PID: ACK, no interrupt, toggle kept
// RULE8 - CPU may write the toggle bit
// RULE9 - Link re-enable clears every toggle bit
// RULE10 - FIFO re-enable clears that toggle bit
// RULE11 - IN busy set on arm until sent
// RULE12 - CPU touches IN FIFO only when idle
// RULE13 - OUT busy high while receiving data
// RULE14 - OUT busy clears on completion, stays clear
// RULE15 - Byte count write arms IN endpoint
// RULE16 - Bits per selected endpoint and direction
`timescale 1ns/1ns
`default_nettype none
`include "endpoint_fifo_control_defines.vh"

module endpoint_fifo_control
#(
  parameter NUM_EP = 10,
  parameter EP_W   = 4
)
(
  input  wire             pclk,
  input  wire             presetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [7:0]       paddr,
  input  wire [31:0]      pwdata,
  output wire [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  output wire             irq,
  output wire             link_enable,
  input  wire             tok_valid,
  input  wire             tok_in,
  input  wire [EP_W-1:0]  tok_ep,
  output wire             reply_valid,
  output wire [1:0]       reply_code,
  output wire             reply_pid,
  output wire [`CNT_W-1:0] reply_count,
  input  wire             in_ack,
  input  wire             out_start,
  input  wire             out_done,
  input  wire             out_ok,
  input  wire             out_pid,
  input  wire [`CNT_W-1:0] out_count,
  output wire             out_ack
);

  localparam SLOT_W = EP_W + 1;
  localparam SLOTS  = 2 * NUM_EP;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [SLOT_W-1:0] sel_reg;
  reg               link_en_reg;
  reg  [`CNT_W-1:0] count_mem [0:SLOTS-1];
  reg  [SLOT_W-1:0] cur_slot_reg;
  reg               reply_valid_reg;
  reg  [1:0]        reply_code_reg;
  reg               reply_pid_reg;
  reg  [`CNT_W-1:0] reply_count_reg;
  reg               out_ack_reg;
  reg  [31:0]       prdata_reg;
  reg               pslverr_reg;
  reg  [31:0]       rd_val;
  reg               hit;
  reg  [1:0]        tok_code;

  wire [SLOTS-1:0]  enable_v;
  wire [SLOTS-1:0]  stall_v;
  wire [SLOTS-1:0]  toggle_v;
  wire [SLOTS-1:0]  busy_v;
  wire [SLOTS-1:0]  ctl_wr_v;
  wire [SLOTS-1:0]  flip_v;
  wire [SLOTS-1:0]  bset_v;
  wire [SLOTS-1:0]  bclr_v;
  wire [`EVT_W-1:0] irq_status;
  wire [`EVT_W-1:0] irq_mask;
  wire [`EVT_W-1:0] events;

  wire              setup_phase;
  wire              access_phase;
  wire              wr_sel;
  wire              wr_ctl;
  wire              wr_cnt;
  wire              wr_lnk;
  wire              wr_sts;
  wire              wr_msk;
  wire              sel_valid;
  wire [SLOT_W-1:0] tok_slot;
  wire              tok_ok;
  wire              tok_take;
  wire              cur_in;
  wire              cur_valid;
  wire              out_match;
  wire              link_rise;

  //////////////////////////////////////////////////////////////////////////////
  // Slot decode
  assign sel_valid = ({{(32-EP_W){1'b0}}, sel_reg[SLOT_W-1:1]} < NUM_EP);
  assign tok_slot  = {tok_ep, tok_in};
  assign tok_ok    = link_en_reg && ({{(32-EP_W){1'b0}}, tok_ep} < NUM_EP);
  assign tok_take  = tok_valid && tok_ok;
  assign cur_in    = (cur_slot_reg[`SEL_DIR_BIT] == `DIR_IN);
  assign cur_valid = ({{(32-EP_W){1'b0}}, cur_slot_reg[SLOT_W-1:1]} < NUM_EP);
  assign out_match = cur_valid && (out_pid == toggle_v[cur_slot_reg]);

  //////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_sel = access_phase && pwrite && (paddr == `OFS_SELECT);
  assign wr_ctl = access_phase && pwrite && (paddr == `OFS_CONTROL);
  assign wr_cnt = access_phase && pwrite && (paddr == `OFS_BYTE_COUNT);
  assign wr_lnk = access_phase && pwrite && (paddr == `OFS_LINK_CONTROL);
  assign wr_sts = access_phase && pwrite && (paddr == `OFS_IRQ_STATUS);
  assign wr_msk = access_phase && pwrite && (paddr == `OFS_IRQ_MASK);
  assign link_rise = wr_lnk && !link_en_reg && pwdata[`LNK_ENABLE_BIT];

  always @*
  begin
    rd_val = 32'h00000000;
    hit    = 1'b1;
    if (paddr == `OFS_SELECT)
      rd_val[SLOT_W-1:0] = sel_reg;
    else if (paddr == `OFS_CONTROL)
    begin
      if (sel_valid)
      begin
        rd_val[`CTL_ENABLE_BIT] = enable_v[sel_reg]; // RULE16
        rd_val[`CTL_STALL_BIT]  = stall_v[sel_reg];
        rd_val[`CTL_TOGGLE_BIT] = toggle_v[sel_reg];
        rd_val[`CTL_BUSY_BIT]   = busy_v[sel_reg];
      end
    end
    else if (paddr == `OFS_BYTE_COUNT)
    begin
      if (sel_valid)
        rd_val[`CNT_W-1:0] = count_mem[sel_reg];
    end
    else if (paddr == `OFS_LINK_CONTROL)
      rd_val[`LNK_ENABLE_BIT] = link_en_reg;
    else if (paddr == `OFS_IRQ_STATUS)
      rd_val[`EVT_W-1:0] = irq_status;
    else if (paddr == `OFS_IRQ_MASK)
      rd_val[`EVT_W-1:0] = irq_mask;
    else
      hit = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB read data and error, captured in setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_reg  <= pwrite ? 32'h00000000 : rd_val;
      pslverr_reg <= !hit;
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg && access_phase;
  assign pready  = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // Select and link control
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_reg     <= `RST_SELECT;
      link_en_reg <= `RST_LINK;
    end
    else
    begin
      if (wr_sel)
        sel_reg <= pwdata[SLOT_W-1:0];
      if (wr_lnk)
        link_en_reg <= pwdata[`LNK_ENABLE_BIT];
    end
  end

  assign link_enable = link_en_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Token reply
  always @*
  begin
    tok_code = `RPL_NONE;
    if (tok_take)
    begin
      if (stall_v[tok_slot])
        tok_code = `RPL_STALL; // RULE2
      else if (!enable_v[tok_slot])
        tok_code = `RPL_NAK;
      else if (tok_in)
        tok_code = busy_v[tok_slot] ? `RPL_DATA : `RPL_NAK; // RULE15
      else
        tok_code = `RPL_DATA;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_slot_reg    <= `RST_SELECT;
      reply_valid_reg <= 1'b0;
      reply_code_reg  <= `RPL_NONE;
      reply_pid_reg   <= 1'b0;
      reply_count_reg <= {`CNT_W{1'b0}};
      out_ack_reg     <= 1'b0;
    end
    else
    begin
      reply_valid_reg <= tok_take;
      out_ack_reg     <= out_done && out_ok; // RULE7
      if (tok_take)
      begin
        cur_slot_reg    <= tok_slot;
        reply_code_reg  <= tok_code;
        reply_pid_reg   <= toggle_v[tok_slot]; // RULE3 RULE5
        reply_count_reg <= count_mem[tok_slot];
      end
    end
  end

  assign reply_valid = reply_valid_reg;
  assign reply_code  = reply_code_reg;
  assign reply_pid   = reply_pid_reg;
  assign reply_count = reply_count_reg;
  assign out_ack     = out_ack_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Byte counts
  always @(posedge pclk)
  begin
    if (out_done && out_ok && out_match && !cur_in)
      count_mem[cur_slot_reg] <= out_count;
    else if (wr_cnt && sel_valid)
      count_mem[sel_reg] <= pwdata[`CNT_W-1:0]; // RULE15
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per slot state
  genvar i;
  generate
    for (i = 0; i < SLOTS; i = i + 1)
    begin : slot
      localparam [SLOT_W-1:0] ID = i;
      wire is_in = (ID[`SEL_DIR_BIT] == `DIR_IN);
      wire is_cur = (cur_slot_reg == ID);
      wire is_sel = sel_valid && (sel_reg == ID);

      assign ctl_wr_v[i] = wr_ctl && is_sel; // RULE16
      assign flip_v[i] = is_cur && (is_in ? in_ack // RULE4
                                          : (out_done && out_ok && out_match)); // RULE6 RULE7
      assign bset_v[i] = (wr_cnt && is_sel && is_in) // RULE11 RULE15
                      || (out_start && is_cur && !is_in
                          && enable_v[i] && !stall_v[i]); // RULE13
      assign bclr_v[i] = is_cur && (is_in ? in_ack : out_done); // RULE14

      endpoint_slot_state u_state
      (
        .pclk         (pclk),
        .presetn      (presetn),
        .cpu_write    (ctl_wr_v[i]),
        .cpu_enable   (pwdata[`CTL_ENABLE_BIT]),
        .cpu_stall    (pwdata[`CTL_STALL_BIT]),
        .cpu_toggle   (pwdata[`CTL_TOGGLE_BIT]), // RULE8
        .toggle_clear (link_rise), // RULE9
        .toggle_flip  (flip_v[i]),
        .busy_set     (bset_v[i]),
        .busy_clear   (bclr_v[i]),
        .enable       (enable_v[i]),
        .stall        (stall_v[i]),
        .toggle       (toggle_v[i]),
        .busy         (busy_v[i])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts
  assign events[`EVT_IN_DONE]  = in_ack && cur_in && cur_valid;
  assign events[`EVT_OUT_DONE] = out_done && out_ok && out_match && !cur_in; // RULE7
  assign events[`EVT_STALL]    = tok_take && (tok_code == `RPL_STALL);

  event_irq_bank u_irq
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .events       (events),
    .status_write (wr_sts),
    .mask_write   (wr_msk),
    .wdata        (pwdata[`EVT_W-1:0]),
    .status       (irq_status),
    .mask         (irq_mask),
    .irq          (irq)
  );

endmodule
`default_nettype wire

//--- test/endpoint_fifo_control_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "endpoint_fifo_control_defines.vh"
module endpoint_fifo_control_asserts
#(
  parameter NUM_EP = 10,
  parameter EP_W   = 4
)
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [31:0]     prdata,
  input wire logic            irq,
  input wire logic            link_enable,
  input wire logic            tok_valid,
  input wire logic [EP_W-1:0] tok_ep,
  input wire logic            reply_valid,
  input wire logic [1:0]      reply_code,
  input wire logic            reply_pid,
  input wire logic            in_ack,
  input wire logic            out_done,
  input wire logic            out_ok,
  input wire logic            out_ack
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  AST_PREADY: assert property (pready)
    else $error("pready low");
  AST_SLVERR: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  AST_PRDATA: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata moved outside setup");
  AST_REPLY: assert property (tok_valid && link_enable && tok_ep < NUM_EP |=> reply_valid)
    else $error("token not answered");
  AST_NO_REPLY: assert property (!tok_valid |=> !reply_valid)
    else $error("reply without token");
  AST_LINK: assert property (tok_valid && !link_enable |=> !reply_valid)
    else $error("reply while link off");
  AST_HOLD: assert property (!reply_valid |-> $stable(reply_code) && $stable(reply_pid))
    else $error("reply fields moved");
  AST_OUT_ACK: assert property (out_ack |-> $past(out_done && out_ok))
    else $error("ack without good packet");
  AST_IRQ_RISE: assert property ($rose(irq) |-> $past(in_ack || out_done || tok_valid || reply_valid || psel))
    else $error("irq rose without event");
  AST_OUT_ACK_GOOD: assert property (out_done && out_ok |=> out_ack)
    else $error("good packet not acked");
  AST_OUT_NO_ACK: assert property (out_done && !out_ok |=> !out_ack)
    else $error("errored packet acked");
  cover property (reply_valid && reply_code == `RPL_STALL);
  cover property (out_ack);
  cover property (irq);
endmodule
bind endpoint_fifo_control endpoint_fifo_control_asserts #(.NUM_EP(NUM_EP), .EP_W(EP_W)) chk_i (.*);
`default_nettype wire

//--- test/usb_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module usb_host_model
(
  input  wire logic       pclk,
  input  wire logic       out_ack,
  output var  logic       tok_valid,
  output var  logic       tok_in,
  output var  logic [3:0] tok_ep,
  output var  logic       in_ack,
  output var  logic       out_start,
  output var  logic       out_done,
  output var  logic       out_ok,
  output var  logic       out_pid,
  output var  logic [6:0] out_count
);
  logic acked = 0;
  initial
  begin
    {tok_valid, tok_in, tok_ep, in_ack, out_start} = 8'h00;
    {out_done, out_ok, out_pid, out_count} = 10'h000;
  end
  ////////////////////////////////////////
  // Released lines show inverted values, except tok_in, which keeps its value
  task token(input logic i, input logic [3:0] e);
    @(posedge pclk);
    tok_valid <= 1;
    tok_in <= i;
    tok_ep <= e;
    @(posedge pclk);
    tok_valid <= 0;
    tok_ep <= ~e;
    @(posedge pclk);
  endtask
  task ack;
    @(posedge pclk);
    in_ack <= 1;
    @(posedge pclk);
    in_ack <= 0;
    @(posedge pclk);
  endtask
  task start;
    @(posedge pclk);
    out_start <= 1;
    @(posedge pclk);
    out_start <= 0;
    @(posedge pclk);
  endtask
  task done(input logic ok, input logic pid, input logic [6:0] cnt);
    @(posedge pclk);
    out_done <= 1;
    out_ok <= ok;
    out_pid <= pid;
    out_count <= cnt;
    @(posedge pclk);
    out_done <= 0;
    out_ok <= ~ok;
    out_pid <= ~pid;
    out_count <= ~cnt;
    @(posedge pclk);
    acked = out_ack;
  endtask
endmodule
`default_nettype wire

//--- test/endpoint_fifo_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "endpoint_fifo_control_defines.vh"
module endpoint_fifo_control_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic        pready, pslverr, irq, link_enable, reply_valid, reply_pid, out_ack, rd_e;
  logic        tok_valid, tok_in, in_ack, out_start, out_done, out_ok, out_pid;
  logic [3:0]  tok_ep;
  logic [1:0]  reply_code;
  logic [6:0]  reply_count, out_count;
  int          fails = 0, check_count = 0;
  always #10 pclk = ~pclk;
  endpoint_fifo_control uut (.*);
  usb_host_model host (.*);
  ////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x)
    begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 32'h0);
    chk(rd_v, x);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  task t_reset;
    rd(`OFS_CONTROL, 32'h8);
    wr(`OFS_SELECT, 32'h13);
    rd(`OFS_CONTROL, 32'h8);
    apb(0, 8'h18, 32'h0);
    chk({rd_v[30:0], rd_e}, 32'h1);
    host.token(1, 4'h9);
    chk(reply_code, `RPL_NONE);
    wr(`OFS_LINK_CONTROL, 32'h1);
    rd(`OFS_LINK_CONTROL, 32'h1);
    chk(link_enable, 1);
  endtask
  task t_in;
    wr(`OFS_SELECT, 32'h03);
    rd(`OFS_CONTROL, 32'h8);
    wr(`OFS_BYTE_COUNT, 32'h05);
    rd(`OFS_CONTROL, 32'h9);
    host.token(1, 4'h1);
    chk({reply_code, reply_pid, reply_count}, {`RPL_DATA, 1'h0, 7'h05});
    rd(`OFS_CONTROL, 32'h9);
    host.ack;
    rd(`OFS_CONTROL, 32'hA);
    host.token(1, 4'h1);
    chk({reply_code, reply_pid}, {`RPL_NAK, 1'h1});
    rd(`OFS_IRQ_STATUS, 32'h1);
    chk(irq, 0);
    wr(`OFS_IRQ_MASK, 32'h7);
    rd(`OFS_IRQ_STATUS, 32'h1);
    chk(irq, 1);
    wr(`OFS_IRQ_STATUS, 32'h1);
    rd(`OFS_IRQ_STATUS, 32'h0);
    chk(irq, 0);
  endtask
  task t_out;
    wr(`OFS_SELECT, 32'h04);
    host.token(0, 4'h2);
    chk({reply_code, reply_pid}, {`RPL_DATA, 1'h0});
    host.start;
    rd(`OFS_CONTROL, 32'h9);
    host.done(1, 0, 7'h03);
    chk(host.acked, 1);
    rd(`OFS_CONTROL, 32'hA);
    rd(`OFS_BYTE_COUNT, 32'h3);
    rd(`OFS_IRQ_STATUS, 32'h2);
    wr(`OFS_IRQ_STATUS, 32'h2);
    host.token(0, 4'h2);
    chk(reply_pid, 1);
    host.start;
    host.done(1, 0, 7'h04);
    chk(host.acked, 1);
    rd(`OFS_CONTROL, 32'hA);
    rd(`OFS_IRQ_STATUS, 32'h0);
    host.start;
    host.done(0, 1, 7'h05);
    chk(host.acked, 0);
    rd(`OFS_CONTROL, 32'hA);
  endtask
  task t_stall;
    for (int i = 0; i < 2; i++)
    begin
      wr(`OFS_SELECT, 32'h04 + i);
      wr(`OFS_CONTROL, 32'hC);
      host.token(i[0], 4'h2);
      chk(reply_code, `RPL_STALL);
    end
    host.token(1, 4'h1);
    chk(reply_code, `RPL_NAK);
  endtask
  task t_toggle;
    wr(`OFS_SELECT, 32'h07);
    wr(`OFS_CONTROL, 32'hA);
    rd(`OFS_CONTROL, 32'hA);
    wr(`OFS_CONTROL, 32'h2);
    wr(`OFS_CONTROL, 32'h8);
    rd(`OFS_CONTROL, 32'h8);
    wr(`OFS_CONTROL, 32'hA);
    wr(`OFS_LINK_CONTROL, 32'h0);
    wr(`OFS_LINK_CONTROL, 32'h1);
    rd(`OFS_CONTROL, 32'h8);
    wr(`OFS_SELECT, 32'h03);
    rd(`OFS_CONTROL, 32'h8);
    wr(`OFS_SELECT, 32'h06);
    wr(`OFS_CONTROL, 32'h0);
    host.token(0, 4'h3);
    chk(reply_code, `RPL_NAK);
    host.start;
    rd(`OFS_CONTROL, 32'h0);
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_in;
    t_out;
    t_stall;
    t_toggle;
    tally_and_finish;
  end
  initial
  begin
    #100000;
    fails++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
